// ==== verilog/aurt_timer.sv ====
/*
  Top of the 12-bit autoreload timer with one PWM channel: Avalon-MM
  register slave, upcounter with autoreload, flags and interrupt lines.
  Assumes one clock clk_sys, a timebase tick and power mode driven by
  logic on that clock, and a pad that resolves pin, enable and GPIO.
*/
// Operation
// - Period is 4096 minus reload counter clock ticks.
// - After reset the counter starts from zero.
// - Overflow loads reload, transfers duty to shadow, drives output high.
// - Counter equal to active duty drives output low until next overflow.
// - Output enable set makes the pin a push-pull waveform output.
// - Invert bit set inverts the waveform before the pin.
// - Duty high write suspends compare until duty low write.
// - Output compare mode uses a written duty value at once.
// - Compare match sets compare flag; interrupt if its enable set.
// - Duty value zero gives no compare events.
// - Each overflow copies duty to shadow; PWM mode compares shadow.
// - Output compare mode compares direct duty, no waveform.
// - Clock select bits 4:3: off, timebase, CPU, reserved; reset clears.
// - Overflow flag set on wrap from FFFh, cleared by status read.
// - Overflow flag stays high one counter clock cycle.
// - Slow mode divides counter input by 32; wait has no effect.
// - Active-halt stops unless timebase clock and overflow enable.
// - Separate overflow and compare interrupts, each with reset-cleared enable.
// - Reload is a 12-bit value in high and low registers.
// - Reading channel status clears the compare flag.
// - Output enable is bit 0; clear releases the pin.
// - Invert bit is bit 1 of channel status, cleared by reset.
`timescale 1ns/1ps
`default_nettype none

module aurt_timer
(
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        rst_b,
  // Avalon-MM slave
  input  wire logic [aurt_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [aurt_pkg::DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic      [aurt_pkg::DATA_W-1:0] avs_readdata,
  output logic                             avs_waitrequest,
  // Timebase and power mode
  input  wire logic                        timebaseClock,
  input  wire aurt_pkg::aurt_power_s       powerMode,
  // PWM pin
  output logic                             pwmOutput,
  output logic                             pwmOutputEn,
  // Interrupt requests
  output logic                             overflowIrq,
  output logic                             compareIrq
);

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    aurt_pkg::aurt_bus_e        bus;
    logic                       waitRequest;
    logic [aurt_pkg::REG_W-1:0] readData;
    logic [1:0]                 counterClockSelect;
    logic                       overflowFlag;
    logic                       overflowIrqEnable;
    logic                       compareIrqEnable;
    logic [aurt_pkg::CNT_W-1:0] counterValue;
    logic [aurt_pkg::CNT_W-1:0] reloadValue;
    logic                       pwmOutEnable;
    logic                       pwmInvert;
    logic                       compareFlag;
    logic [aurt_pkg::CNT_W-1:0] dutyValue;
    logic                       dutyLock;
    logic                       overflowIrq;
    logic                       compareIrq;
  } aurt_top_s;

  aurt_top_s                  st;
  aurt_top_s                  next_st;
  logic                       counterTick;
  logic                       matchPulse;
  logic                       overflowEvent;
  logic [aurt_pkg::CNT_W-1:0] counterNext;
  logic                       access;
  logic                       wrStrobe;
  logic                       rdStrobe;
  logic [aurt_pkg::IDX_W-1:0] index;
  logic [aurt_pkg::REG_W-1:0] wrByte;
  logic [aurt_pkg::REG_W-1:0] readMux;
  aurt_pkg::aurt_chan_s       chan;

  // ********************************************************************
  // Counter clock
  // ********************************************************************
  aurt_tick_gen u_tick
  (
    .clk_sys            (clk_sys),
    .rst_b              (rst_b),
    .counterClockSelect (st.counterClockSelect),
    .overflowIrqEnable  (st.overflowIrqEnable),
    .timebaseClock      (timebaseClock),
    .powerMode          (powerMode),
    .counterTick        (counterTick)
  );

  // ********************************************************************
  // Compare channel
  // ********************************************************************
  assign chan = '{pwmOutEnable: st.pwmOutEnable,
                  pwmInvert:    st.pwmInvert,
                  dutyLock:     st.dutyLock,
                  dutyValue:    st.dutyValue};

  aurt_compare u_cmp
  (
    .clk_sys       (clk_sys),
    .rst_b         (rst_b),
    .counterTick   (counterTick),
    .overflowEvent (overflowEvent),
    .counterNext   (counterNext),
    .chan          (chan),
    .matchPulse    (matchPulse),
    .pwmOutput     (pwmOutput),
    .pwmOutputEn   (pwmOutputEn)
  );

  // ********************************************************************
  // Upcounter
  // ********************************************************************
  always_comb
  begin
    overflowEvent = counterTick &&
                    (st.counterValue == aurt_pkg::CNT_MAX);
    if (!counterTick)
    begin
      counterNext = st.counterValue;
    end
    else if (overflowEvent)
    begin
      counterNext = st.reloadValue;
    end
    else
    begin
      counterNext = st.counterValue + 12'h001;
    end
  end

  // ********************************************************************
  // Register read multiplexer
  // ********************************************************************
  always_comb
  begin
    index = avs_address[aurt_pkg::ADDR_W-1:2];
    readMux = aurt_pkg::REG_ZERO;
    case (index)
      aurt_pkg::IDX_TIMER_CTRL_STATUS:
      begin
        readMux[aurt_pkg::TCS_CK_HI_BIT:aurt_pkg::TCS_CK_LO_BIT] =
          st.counterClockSelect;
        readMux[aurt_pkg::TCS_OVF_BIT]   = st.overflowFlag;
        readMux[aurt_pkg::TCS_OVERFLOW_IRQ_ENABLE_BIT] = st.overflowIrqEnable;
        readMux[aurt_pkg::TCS_COMPARE_IRQ_ENABLE_BIT] = st.compareIrqEnable;
      end
      aurt_pkg::IDX_COUNTER_HIGH:
      begin
        // Upper nibble always zero
        readMux[aurt_pkg::HIGH_NIB_W-1:0] =
          st.counterValue[aurt_pkg::CNT_W-1:aurt_pkg::REG_W];
      end
      aurt_pkg::IDX_COUNTER_LOW:
      begin
        readMux = st.counterValue[aurt_pkg::REG_W-1:0];
      end
      aurt_pkg::IDX_RELOAD_HIGH:
      begin
        readMux[aurt_pkg::HIGH_NIB_W-1:0] =
          st.reloadValue[aurt_pkg::CNT_W-1:aurt_pkg::REG_W];
      end
      aurt_pkg::IDX_RELOAD_LOW:
      begin
        readMux = st.reloadValue[aurt_pkg::REG_W-1:0];
      end
      aurt_pkg::IDX_OUTPUT_CONTROL:
      begin
        readMux[aurt_pkg::OCR_OE_BIT] = st.pwmOutEnable;
      end
      aurt_pkg::IDX_CHANNEL_CTRL_STAT:
      begin
        readMux[aurt_pkg::CCS_INV_BIT]  = st.pwmInvert;
        readMux[aurt_pkg::CCS_CMPF_BIT] = st.compareFlag;
      end
      aurt_pkg::IDX_DUTY_HIGH:
      begin
        readMux[aurt_pkg::HIGH_NIB_W-1:0] =
          st.dutyValue[aurt_pkg::CNT_W-1:aurt_pkg::REG_W];
      end
      aurt_pkg::IDX_DUTY_LOW:
      begin
        readMux = st.dutyValue[aurt_pkg::REG_W-1:0];
      end
      default:
      begin
        readMux = aurt_pkg::REG_ZERO;
      end
    endcase
  end

  // ********************************************************************
  // Bus handshake, register writes, flags
  // ********************************************************************
  always_comb
  begin
    next_st = st;
    // A request completes at the edge where waitrequest is low
    access = (st.bus == aurt_pkg::BUS_ACK);
    wrStrobe = access && avs_write && avs_byteenable[0];
    rdStrobe = access && avs_read;
    wrByte = avs_writedata[aurt_pkg::REG_W-1:0];

    case (st.bus)
      aurt_pkg::BUS_IDLE:
      begin
        if (avs_read || avs_write)
        begin
          next_st.bus = aurt_pkg::BUS_ACK;
          next_st.readData = readMux;
        end
      end
      aurt_pkg::BUS_ACK:
      begin
        next_st.bus = aurt_pkg::BUS_IDLE;
      end
      default:
      begin
        next_st.bus = aurt_pkg::BUS_IDLE;
      end
    endcase
    next_st.waitRequest = (next_st.bus != aurt_pkg::BUS_ACK);

    next_st.counterValue = counterNext;

    if (wrStrobe)
    begin
      case (index)
        aurt_pkg::IDX_TIMER_CTRL_STATUS:
        begin
          next_st.counterClockSelect =
            wrByte[aurt_pkg::TCS_CK_HI_BIT:aurt_pkg::TCS_CK_LO_BIT];
          next_st.overflowIrqEnable = wrByte[aurt_pkg::TCS_OVERFLOW_IRQ_ENABLE_BIT];
          next_st.compareIrqEnable = wrByte[aurt_pkg::TCS_COMPARE_IRQ_ENABLE_BIT];
        end
        aurt_pkg::IDX_RELOAD_HIGH:
        begin
          next_st.reloadValue[aurt_pkg::CNT_W-1:aurt_pkg::REG_W] =
            wrByte[aurt_pkg::HIGH_NIB_W-1:0];
        end
        aurt_pkg::IDX_RELOAD_LOW:
        begin
          next_st.reloadValue[aurt_pkg::REG_W-1:0] = wrByte;
        end
        aurt_pkg::IDX_OUTPUT_CONTROL:
        begin
          next_st.pwmOutEnable = wrByte[aurt_pkg::OCR_OE_BIT];
        end
        aurt_pkg::IDX_CHANNEL_CTRL_STAT:
        begin
          next_st.pwmInvert = wrByte[aurt_pkg::CCS_INV_BIT];
        end
        aurt_pkg::IDX_DUTY_HIGH:
        begin
          next_st.dutyValue[aurt_pkg::CNT_W-1:aurt_pkg::REG_W] =
            wrByte[aurt_pkg::HIGH_NIB_W-1:0];
          next_st.dutyLock = 1'b1;
        end
        aurt_pkg::IDX_DUTY_LOW:
        begin
          next_st.dutyValue[aurt_pkg::REG_W-1:0] = wrByte;
          next_st.dutyLock = 1'b0;
        end
        default:
        begin
          // Counter and unmapped words ignore writes
          next_st.dutyLock = st.dutyLock;
        end
      endcase
    end

    // Flag lives one counter tick; a read also clears; set wins
    if (counterTick ||
        (rdStrobe && index == aurt_pkg::IDX_TIMER_CTRL_STATUS))
    begin
      next_st.overflowFlag = 1'b0;
    end
    if (overflowEvent)
    begin
      next_st.overflowFlag = 1'b1;
    end

    if (rdStrobe && index == aurt_pkg::IDX_CHANNEL_CTRL_STAT)
    begin
      next_st.compareFlag = 1'b0;
    end
    if (matchPulse)
    begin
      next_st.compareFlag = 1'b1;
    end

    // Separate lines, so each keeps its own vector and wake-up
    next_st.overflowIrq = next_st.overflowFlag &&
                          next_st.overflowIrqEnable;
    next_st.compareIrq = next_st.compareFlag &&
                         next_st.compareIrqEnable;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st.bus                <= aurt_pkg::BUS_IDLE;
      st.waitRequest        <= 1'b1;
      st.readData           <= aurt_pkg::REG_ZERO;
      st.counterClockSelect <= aurt_pkg::CLK_OFF;
      st.overflowFlag       <= 1'b0;
      st.overflowIrqEnable  <= 1'b0;
      st.compareIrqEnable   <= 1'b0;
      st.counterValue       <= aurt_pkg::CNT_RESET;
      st.reloadValue        <= aurt_pkg::CNT_RESET;
      st.pwmOutEnable       <= 1'b0;
      st.pwmInvert          <= 1'b0;
      st.compareFlag        <= 1'b0;
      st.dutyValue          <= aurt_pkg::DUTY_NONE;
      st.dutyLock           <= 1'b0;
      st.overflowIrq        <= 1'b0;
      st.compareIrq         <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign avs_readdata    = {{(aurt_pkg::DATA_W-aurt_pkg::REG_W){1'b0}},
                            st.readData};
  assign avs_waitrequest = st.waitRequest;
  assign overflowIrq     = st.overflowIrq;
  assign compareIrq      = st.compareIrq;

endmodule

`default_nettype wire

// ==== verilog/aurt_pkg.sv ====
/*
  Shared constants and types of the 12-bit autoreload timer with one
  PWM channel: register indices, field positions, clock select codes,
  counter limits and the structs passed between the timer modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package aurt_pkg;

  // ********************************************************************
  // Widths
  // ********************************************************************
  localparam int unsigned CNT_W  = 12;
  localparam int unsigned REG_W  = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W  = 6;
  localparam int unsigned PRE_W  = 5;

  // ********************************************************************
  // Register indices, byte address is index times four
  // ********************************************************************
  localparam logic [IDX_W-1:0] IDX_TIMER_CTRL_STATUS  = 6'h0D;
  localparam logic [IDX_W-1:0] IDX_COUNTER_HIGH       = 6'h0E;
  localparam logic [IDX_W-1:0] IDX_COUNTER_LOW        = 6'h0F;
  localparam logic [IDX_W-1:0] IDX_RELOAD_HIGH        = 6'h10;
  localparam logic [IDX_W-1:0] IDX_RELOAD_LOW         = 6'h11;
  localparam logic [IDX_W-1:0] IDX_OUTPUT_CONTROL     = 6'h12;
  localparam logic [IDX_W-1:0] IDX_CHANNEL_CTRL_STAT  = 6'h13;
  localparam logic [IDX_W-1:0] IDX_DUTY_HIGH          = 6'h17;
  localparam logic [IDX_W-1:0] IDX_DUTY_LOW           = 6'h18;

  // ********************************************************************
  // Field positions and reset values
  // ********************************************************************
  localparam int unsigned TCS_COMPARE_IRQ_ENABLE_BIT = 0;
  localparam int unsigned TCS_OVERFLOW_IRQ_ENABLE_BIT = 1;
  localparam int unsigned TCS_OVF_BIT   = 2;
  localparam int unsigned TCS_CK_LO_BIT = 3;
  localparam int unsigned TCS_CK_HI_BIT = 4;
  localparam int unsigned OCR_OE_BIT    = 0;
  localparam int unsigned CCS_CMPF_BIT  = 0;
  localparam int unsigned CCS_INV_BIT   = 1;
  localparam int unsigned HIGH_NIB_W    = 4;
  localparam logic [CNT_W-1:0] CNT_RESET = 12'h000;
  localparam logic [CNT_W-1:0] CNT_MAX   = 12'hFFF;
  localparam logic [CNT_W-1:0] DUTY_NONE = 12'h000;
  localparam logic [REG_W-1:0] REG_ZERO  = 8'h00;

  // ********************************************************************
  // Counter clock select codes and slow-mode prescaler
  // ********************************************************************
  localparam logic [1:0] CLK_OFF      = 2'h0;
  localparam logic [1:0] CLK_TIMEBASE = 2'h1;
  localparam logic [1:0] CLK_CPU      = 2'h2;
  localparam logic [1:0] CLK_RESERVED = 2'h3;
  localparam logic [PRE_W-1:0] PRE_RESET = 5'h00;
  localparam logic [PRE_W-1:0] PRE_LAST  = 5'h1F;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic {BUS_IDLE, BUS_ACK} aurt_bus_e;

  typedef struct packed {
    logic slow;
    logic activeHalt;
    logic halt;
  } aurt_power_s;

  typedef struct packed {
    logic             pwmOutEnable;
    logic             pwmInvert;
    logic             dutyLock;
    logic [CNT_W-1:0] dutyValue;
  } aurt_chan_s;

endpackage

`default_nettype wire

// ==== verilog/aurt_tick_gen.sv ====
/*
  Counter clock tick generator: picks the counter clock source, divides
  it by 32 in slow mode, stops it in halt, and in active-halt unless timebase clock and overflow enable.
  Assumes the timebase tick and the power mode come from logic on
  clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

module aurt_tick_gen
(
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_b,
  // Selection
  input  wire logic [1:0]         counterClockSelect,
  input  wire logic               overflowIrqEnable,
  input  wire logic               timebaseClock,
  input  wire aurt_pkg::aurt_power_s powerMode,
  // Tick
  output logic                    counterTick
);

  typedef struct packed {
    logic [aurt_pkg::PRE_W-1:0] prescale;
    logic                       tick;
  } aurt_tick_s;

  aurt_tick_s st;
  aurt_tick_s next_st;
  logic       source;
  logic       running;

  always_comb
  begin
    next_st = st;
    next_st.tick = 1'b0;
    // Off and reserved give no edge at all
    source = (counterClockSelect == aurt_pkg::CLK_TIMEBASE) ? timebaseClock
           : (counterClockSelect == aurt_pkg::CLK_CPU);
    running = !powerMode.halt &&
              (!powerMode.activeHalt ||
               (counterClockSelect == aurt_pkg::CLK_TIMEBASE &&
                overflowIrqEnable));
    if (running && source)
    begin
      if (powerMode.slow)
      begin
        next_st.prescale = st.prescale + 5'h01;
        next_st.tick = (st.prescale == aurt_pkg::PRE_LAST);
      end
      else
      begin
        next_st.tick = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st <= '{prescale: aurt_pkg::PRE_RESET, tick: 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign counterTick = st.tick;

endmodule

`default_nettype wire

// ==== verilog/aurt_compare.sv ====
/*
  Compare unit of the PWM channel: duty shadow copy, match detection,
  waveform level, polarity and pin drive.
  Assumes the counter tick, overflow pulse and next count arrive in the
  same clk_sys cycle from the timer core.
*/
`timescale 1ns/1ps
`default_nettype none

module aurt_compare
(
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst_b,
  // Counter side
  input  wire logic                       counterTick,
  input  wire logic                       overflowEvent,
  input  wire logic [aurt_pkg::CNT_W-1:0] counterNext,
  input  wire aurt_pkg::aurt_chan_s       chan,
  // Results
  output logic                            matchPulse,
  output logic                            pwmOutput,
  output logic                            pwmOutputEn
);

  typedef struct packed {
    logic [aurt_pkg::CNT_W-1:0] shadow;
    logic                       level;
    logic                       match;
    logic                       pin;
    logic                       pinEn;
  } aurt_cmp_s;

  aurt_cmp_s                  st;
  aurt_cmp_s                  next_st;
  logic [aurt_pkg::CNT_W-1:0] target;
  logic                       hit;

  always_comb
  begin
    next_st = st;
    if (overflowEvent)
    begin
      // Copied even when only the high byte is new
      next_st.shadow = chan.dutyValue;
      next_st.level = 1'b1;
    end
    target = chan.pwmOutEnable ? next_st.shadow
                               : chan.dutyValue;
    hit = counterTick && !chan.dutyLock &&
          (target != aurt_pkg::DUTY_NONE) &&
          (counterNext == target);
    next_st.match = hit;
    if (hit)
    begin
      next_st.level = 1'b0;
    end
    // Released pin carries nothing in output compare mode
    next_st.pinEn = chan.pwmOutEnable;
    next_st.pin = chan.pwmOutEnable &&
                  (next_st.level ^ chan.pwmInvert);
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st <= '{shadow: aurt_pkg::CNT_RESET, level: 1'b0, match: 1'b0,
              pin: 1'b0, pinEn: 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign matchPulse  = st.match;
  assign pwmOutput   = st.pin;
  assign pwmOutputEn = st.pinEn;

endmodule

`default_nettype wire

// ==== tb/aurt_load_model.sv ====
/*
  External load on the PWM pin: measures period and high time.
  Assumes a pull-down on the pin while the timer releases it.
*/
`timescale 1ns/1ps
`default_nettype none

module aurt_load_model
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // Pin
  input  wire logic pwmOutput,
  input  wire logic pwmOutputEn,
  // Measurements
  output var  int   highCycles,
  output var  int   periodCycles
);
  logic pinLevel;
  logic lastLevel;
  int   run;
  int   high;

  // Released pin falls to the pull-down level
  assign pinLevel = pwmOutputEn ? pwmOutput : 1'b0;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lastLevel    <= 1'b0;
      run          <= 0;
      high         <= 0;
      highCycles   <= 0;
      periodCycles <= 0;
    end
    else
    begin
      lastLevel <= pinLevel;
      run       <= run + 1;
      high      <= high + (pinLevel ? 1 : 0);
      if (pinLevel && !lastLevel)
      begin
        periodCycles <= run;
        highCycles   <= high;
        run          <= 1;
        high         <= 1;
      end
    end
  end
endmodule

`default_nettype wire

// ==== tb/aurt_timer_props.sv ====
/*
  Port checker of the timer: bus handshake, read data, pin drive.
  Assumes it is bound into every aurt_timer instance.
*/
`timescale 1ns/1ps
`default_nettype none

module aurt_timer_props
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // Bus and pin
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  input  wire logic        pwmOutput,
  input  wire logic        pwmOutputEn
);
  logic [5:0] idx;
  assign idx = avs_address[7:2];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_ack; !avs_waitrequest; endsequence
  sequence s_rd_ack; !avs_waitrequest && avs_read; endsequence
  property p_answer; s_req |=> s_ack; endproperty
  property p_one_cycle; s_ack |=> avs_waitrequest; endproperty
  property p_quiet; !avs_read && !avs_write && avs_waitrequest
    |=> avs_waitrequest; endproperty
  property p_upper; s_ack |-> avs_readdata[31:8] == 24'h00_0000;
  endproperty
  property p_cnt_high; s_rd_ack and idx == aurt_pkg::IDX_COUNTER_HIGH
    |-> avs_readdata[7:4] == 4'h0; endproperty
  property p_chan_rsv; s_rd_ack and idx == aurt_pkg::IDX_CHANNEL_CTRL_STAT
    |-> avs_readdata[7:2] == 6'h00; endproperty
  property p_released; !pwmOutputEn |-> !pwmOutput; endproperty
  property p_en_cause; $changed(pwmOutputEn) |-> $past(avs_write, 2)
    && $past(idx, 2) == aurt_pkg::IDX_OUTPUT_CONTROL; endproperty
  a_answer: assert property (p_answer)
    else $error("no answer one cycle after request");
  a_one_cycle: assert property (p_one_cycle)
    else $error("waitrequest low too long");
  a_quiet: assert property (p_quiet)
    else $error("answer without request");
  a_upper: assert property (p_upper)
    else $error("upper read data not zero");
  a_cnt_high: assert property (p_cnt_high)
    else $error("counter high upper nibble not zero");
  a_chan_rsv: assert property (p_chan_rsv)
    else $error("channel status reserved bits set");
  a_released: assert property (p_released)
    else $error("pin high while released");
  a_en_cause: assert property (p_en_cause)
    else $error("pin enable moved without control write");
endmodule

bind aurt_timer aurt_timer_props aurt_timer_props_inst (.clk_sys(clk_sys),
  .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .pwmOutput(pwmOutput),
  .pwmOutputEn(pwmOutputEn));

`default_nettype wire

// ==== tb/aurt_timer_test.sv ====
/*
  Self-checking bench of the timer through its register bus.
  Assumes the load model and the bound checker are compiled with it.
*/
`timescale 1ns/1ps
`default_nettype none

module aurt_timer_test;
  logic clk_sys, rst_b, timebaseClock, avs_read, avs_write, seen;
  logic [7:0]  avs_address, rd, rd2;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic [2:0]  tbDiv = '0;
  logic avs_waitrequest, pwmOutput, pwmOutputEn, overflowIrq, compareIrq;
  aurt_pkg::aurt_power_s powerMode;
  int fail_count, compares, highCycles, periodCycles;
  logic [5:0] idxList [10] = '{6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h11,
    6'h12, 6'h13, 6'h17, 6'h18, 6'h3F};

  aurt_timer aurt_timer_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .timebaseClock(timebaseClock), .powerMode(powerMode),
    .pwmOutput(pwmOutput), .pwmOutputEn(pwmOutputEn),
    .overflowIrq(overflowIrq), .compareIrq(compareIrq));
  aurt_load_model aurt_load_model_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .pwmOutput(pwmOutput), .pwmOutputEn(pwmOutputEn),
    .highCycles(highCycles), .periodCycles(periodCycles));

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Timebase tick every eighth clock keeps that input moving
  always @(posedge clk_sys)
  begin
    tbDiv <= tbDiv + 3'h1;
    timebaseClock <= (tbDiv == 3'h7);
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t saw %h wanted %h", $time, got, exp);
    end
  endtask
  // A spare edge first so two requests never meet in one time step
  task automatic busAccess(input logic wr, input logic [5:0] idx,
    input logic [7:0] data, output logic [7:0] got);
    @(posedge clk_sys);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h00_0000, data};
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    got = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] data);
    busAccess(1'b1, idx, data, rd2);
  endtask
  task automatic readCheck(input logic [5:0] idx, input logic [7:0] exp);
    busAccess(1'b0, idx, 8'h00, rd2);
    check(rd2, exp);
  endtask
  task automatic waitIrq(input logic cmp, input int lim);
    seen = 1'b0;
    for (int i = 0; i < lim && !seen; i++)
    begin
      @(posedge clk_sys);
      seen = ((cmp ? compareIrq : overflowIrq) === 1'b1);
    end
  endtask
  task automatic summarize;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    summarize();
  end

  initial
  begin
    {rst_b, avs_read, avs_write} = 3'h0;
    {avs_address, avs_writedata} = '0;
    {fail_count, compares} = '0;
    avs_byteenable = 4'h1;
    powerMode = '0;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    wr(6'h3F, 8'hFF);
    wr(aurt_pkg::IDX_COUNTER_LOW, 8'h55);
    foreach (idxList[i]) readCheck(idxList[i], 8'h00);
    $display("test reset values done");
    wr(aurt_pkg::IDX_RELOAD_HIGH, 8'h0F);
    wr(aurt_pkg::IDX_RELOAD_LOW, 8'h00);
    wr(aurt_pkg::IDX_DUTY_HIGH, 8'h0F);
    wr(aurt_pkg::IDX_DUTY_LOW, 8'hC0);
    wr(aurt_pkg::IDX_OUTPUT_CONTROL, 8'h01);
    wr(aurt_pkg::IDX_TIMER_CTRL_STATUS, 8'h10);
    repeat (5000) @(posedge clk_sys);
    check(periodCycles, 256);
    check(highCycles, 192);
    wr(aurt_pkg::IDX_CHANNEL_CTRL_STAT, 8'h02);
    repeat (800) @(posedge clk_sys);
    check(highCycles, 64);
    $display("test pwm waveform done");
    wr(aurt_pkg::IDX_TIMER_CTRL_STATUS, 8'h12);
    waitIrq(1'b0, 300);
    check(seen, 1'b1);
    powerMode <= 3'b001;
    busAccess(1'b0, aurt_pkg::IDX_COUNTER_LOW, 8'h00, rd);
    repeat (20) @(posedge clk_sys);
    readCheck(aurt_pkg::IDX_COUNTER_LOW, rd);
    powerMode <= 3'b000;
    $display("test overflow and halt done");
    wr(aurt_pkg::IDX_OUTPUT_CONTROL, 8'h00);
    readCheck(aurt_pkg::IDX_CHANNEL_CTRL_STAT, 8'h03);
    wr(aurt_pkg::IDX_TIMER_CTRL_STATUS, 8'h11);
    waitIrq(1'b1, 300);
    check(seen, 1'b1);
    check(pwmOutputEn, 1'b0);
    readCheck(aurt_pkg::IDX_CHANNEL_CTRL_STAT, 8'h03);
    readCheck(aurt_pkg::IDX_CHANNEL_CTRL_STAT, 8'h02);
    wr(aurt_pkg::IDX_DUTY_HIGH, 8'h0F);
    waitIrq(1'b1, 600);
    check(seen, 1'b0);
    wr(aurt_pkg::IDX_DUTY_LOW, 8'hA0);
    waitIrq(1'b1, 300);
    check(seen, 1'b1);
    wr(aurt_pkg::IDX_RELOAD_HIGH, 8'h00);
    wr(aurt_pkg::IDX_DUTY_HIGH, 8'h00);
    wr(aurt_pkg::IDX_DUTY_LOW, 8'h00);
    readCheck(aurt_pkg::IDX_CHANNEL_CTRL_STAT, 8'h03);
    waitIrq(1'b1, 600);
    check(seen, 1'b0);
    $display("test output compare done");
    summarize();
  end
endmodule

`default_nettype wire
